/* core/i2c_slave_pkg.sv */
// constants shared by the serial slave controller files
package i2c_slave_pkg;
	localparam logic [6:0] SLAVE_ADDR_7 = 7'h36; // write form 8'h6c, read form 8'h6d
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_BIT_INDEX = 4'h9;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int SYNC_STAGES = 2;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK,
		ST_IGNORE
	} link_state_t;
endpackage

/* core/pin_sync.sv */
// two-flop synchroniser for one pin input
`timescale 1ns/1ps
module pin_sync (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic pin_in,
	output logic pin_out
);
	logic stage_one;

	// first flop feeds only the second
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			stage_one <= 1'b1;
			pin_out <= 1'b1;
		end else begin
			stage_one <= pin_in;
			pin_out <= stage_one;
		end
	end
endmodule // pin_sync

/* core/line_edges.sv */
// edge and bus condition detector on synchronised scl and sda
`timescale 1ns/1ps
module line_edges (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_seen,
	output logic stop_seen
);
	logic scl_prev;
	logic sda_prev;

	// previous samples
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_prev <= scl;
			sda_prev <= sda;
		end
	end

	// sda change while scl high marks start or stop
	assign scl_rise = scl & ~scl_prev;
	assign scl_fall = ~scl & scl_prev;
	assign start_seen = scl & scl_prev & sda_prev & ~sda;
	assign stop_seen = scl & scl_prev & ~sda_prev & sda;
endmodule // line_edges

/* core/i2c_slave_controller.sv */
// serial slave controller: fixed-address byte receiver and transmitter
//
// Operation
// - answer only to fixed slave address 0x36 (0x6c write form, 0x6d read form), not software changeable
// - when active, clock pin and data pin are inputs carrying scl and sda
// - data line driven only low; released otherwise, pull-up gives high
// - power-down disables interface; pins keep software-configured state
// - active only with slave enable set; interface then owns pin direction
// - each pin pull-up on only when both its control bits are set
// - after activation wait for start, shift 8 address bits, compare
// - on match drive sda low in 9th pulse and set address match flag
// - acknowledge each written data byte; completion sets receive full flag
// - reading shared data register returns byte and clears receive full flag
// - keep receiving until stop; stop sets the stop received flag
// - address lsb selects read; read address sets read direction flag
// - in reads accept new byte when transmit full clear; send until master nack or stop
// - overflow set when byte received before previous one was read
// - overflow set when software writes before previous byte moved to shifter
// - in program or debug mode refuse power-down requests from the bus
`timescale 1ns/1ps
module i2c_slave_controller
	import i2c_slave_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic serial_slave_enable,
	input wire logic general_call_enable,
	input wire logic power_down_req,
	input wire logic bus_power_down_cmd,
	input wire logic prog_debug_mode,
	input wire logic clock_pin_pull_ctrl_a,
	input wire logic clock_pin_pull_ctrl_b,
	input wire logic data_pin_pull_ctrl_a,
	input wire logic data_pin_pull_ctrl_b,
	input wire logic sw_clock_pin_out,
	input wire logic sw_clock_pin_oe,
	input wire logic sw_data_pin_out,
	input wire logic sw_data_pin_oe,
	input wire logic clock_port_pin_in,
	input wire logic data_port_pin_in,
	input wire logic data_read_strobe,
	input wire logic data_write_strobe,
	input wire logic [7:0] data_write_value,
	input wire logic flag_clear_strobe,
	output logic clock_port_pin_out,
	output logic clock_port_pin_oe,
	output logic data_port_pin_out,
	output logic data_port_pin_oe,
	output logic clock_pin_pullup_en,
	output logic data_pin_pullup_en,
	output logic [7:0] shared_data_register,
	output logic address_match_flag,
	output logic receive_buffer_full_flag,
	output logic transmit_buffer_full_flag,
	output logic read_direction_flag,
	output logic stop_received_flag,
	output logic data_overflow_flag,
	output logic powered_down
);
	import i2c_slave_pkg::*;

	// -------------------------------------------------------------
	// pin sampling and bus conditions
	// -------------------------------------------------------------
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic active;

	pin_sync u_scl_sync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pin_in(clock_port_pin_in),
		.pin_out(scl)
	);

	pin_sync u_sda_sync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pin_in(data_port_pin_in),
		.pin_out(sda)
	);

	line_edges u_edges (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.scl(scl),
		.sda(sda),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_seen(start_seen),
		.stop_seen(stop_seen)
	);

	// -------------------------------------------------------------
	// power state
	// -------------------------------------------------------------
	// bus power-down commands are ignored in program or debug mode
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			powered_down <= 1'b0;
		end else if (power_down_req) begin
			powered_down <= 1'b1;
		end else if (bus_power_down_cmd && !prog_debug_mode) begin
			powered_down <= 1'b1;
		end else if (!power_down_req && !bus_power_down_cmd && powered_down
			&& serial_slave_enable && !prog_debug_mode) begin
			powered_down <= powered_down; // wake handled by system reset
		end
	end

	assign active = serial_slave_enable && !powered_down;

	// -------------------------------------------------------------
	// bit engine
	// -------------------------------------------------------------
	link_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] tx_hold;
	logic sda_low;
	logic tx_load;
	logic rx_done;
	logic master_nack;

	// receive shift on rising scl, count bits per byte
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shift <= DATA_RESET;
			master_nack <= 1'b0;
		end else if (!active || stop_seen) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
		end else if (start_seen) begin
			state <= ST_ADDR;
			bit_cnt <= 4'h0;
		end else begin
			unique case (state)
				ST_IDLE, ST_IGNORE: begin
					bit_cnt <= 4'h0;
				end
				ST_ADDR, ST_RX: begin
					if (scl_rise) begin
						shift <= {shift[6:0], sda};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
						if (state == ST_RX) begin
							state <= ST_RX_ACK;
						end else if (shift[7:1] == SLAVE_ADDR_7) begin
							state <= ST_ADDR_ACK;
						end else begin
							state <= ST_IGNORE;
						end
					end
				end
				ST_ADDR_ACK, ST_RX_ACK: begin
					if (scl_rise) begin
						bit_cnt <= ACK_BIT_INDEX;
					end else if (scl_fall && bit_cnt == ACK_BIT_INDEX) begin
						bit_cnt <= 4'h0;
						if (state == ST_ADDR_ACK && read_direction_flag) begin
							state <= ST_TX;
						end else begin
							state <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
							state <= ST_TX_ACK;
						end
						bit_cnt <= bit_cnt + 4'h1;
						shift <= {shift[6:0], 1'b1};
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						master_nack <= sda;
					end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
						bit_cnt <= 4'h0;
						state <= master_nack ? ST_IGNORE : ST_TX;
					end
				end
			endcase
			if (tx_load) begin
				shift <= tx_hold;
			end
		end
	end

	// byte done, and loading of transmit byte on entry to a byte
	assign rx_done = (state == ST_RX) && scl_fall && (bit_cnt == BITS_PER_BYTE);
	assign tx_load = transmit_buffer_full_flag && scl_fall
		&& ((state == ST_ADDR_ACK && bit_cnt == ACK_BIT_INDEX && read_direction_flag)
		|| (state == ST_TX_ACK && bit_cnt == BITS_PER_BYTE && !master_nack));

	// data pin low level: ack slots and zero bits of transmit data
	always_comb begin
		unique case (state)
			ST_ADDR_ACK, ST_RX_ACK: sda_low = 1'b1;
			ST_TX: sda_low = !shift[7];
			default: sda_low = 1'b0;
		endcase
	end

	// -------------------------------------------------------------
	// software data register and flags
	// -------------------------------------------------------------
	// transmit holding byte
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tx_hold <= DATA_RESET;
			transmit_buffer_full_flag <= 1'b0;
		end else if (data_write_strobe) begin
			tx_hold <= data_write_value;
			transmit_buffer_full_flag <= 1'b1;
		end else if (tx_load || !active) begin
			transmit_buffer_full_flag <= 1'b0;
		end
	end

	// shared data register shows received byte or last written byte
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			shared_data_register <= DATA_RESET;
		end else if (rx_done) begin
			shared_data_register <= shift;
		end else if (data_write_strobe) begin
			shared_data_register <= data_write_value;
		end
	end

	// receive full: set wins over clear on read
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			receive_buffer_full_flag <= 1'b0;
		end else if (rx_done) begin
			receive_buffer_full_flag <= 1'b1;
		end else if (data_read_strobe) begin
			receive_buffer_full_flag <= 1'b0;
		end
	end

	// overflow: late read or early write
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			data_overflow_flag <= 1'b0;
		end else if (rx_done && receive_buffer_full_flag && !data_read_strobe) begin
			data_overflow_flag <= 1'b1;
		end else if (data_write_strobe && transmit_buffer_full_flag && !tx_load) begin
			data_overflow_flag <= 1'b1;
		end else if (flag_clear_strobe) begin
			data_overflow_flag <= 1'b0;
		end
	end

	// address match and direction, stop flag
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			address_match_flag <= 1'b0;
			read_direction_flag <= 1'b0;
		end else if (state == ST_ADDR && scl_fall && bit_cnt == BITS_PER_BYTE
			&& shift[7:1] == SLAVE_ADDR_7) begin
			address_match_flag <= 1'b1;
			read_direction_flag <= shift[0];
		end else if (start_seen || flag_clear_strobe) begin
			address_match_flag <= 1'b0;
			read_direction_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			stop_received_flag <= 1'b0;
		end else if (active && stop_seen) begin
			stop_received_flag <= 1'b1;
		end else if (flag_clear_strobe || start_seen) begin
			stop_received_flag <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// pin drivers
	// -------------------------------------------------------------
	// interface owns direction when active; otherwise software settings stand
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			clock_port_pin_out <= 1'b0;
			clock_port_pin_oe <= 1'b0;
			data_port_pin_out <= 1'b0;
			data_port_pin_oe <= 1'b0;
		end else if (active) begin
			clock_port_pin_out <= 1'b0;
			clock_port_pin_oe <= 1'b0;
			data_port_pin_out <= 1'b0;
			data_port_pin_oe <= sda_low;
		end else begin
			clock_port_pin_out <= sw_clock_pin_out;
			clock_port_pin_oe <= sw_clock_pin_oe;
			data_port_pin_out <= sw_data_pin_out;
			data_port_pin_oe <= sw_data_pin_oe;
		end
	end

	// pull-ups need both control bits
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			clock_pin_pullup_en <= 1'b0;
			data_pin_pullup_en <= 1'b0;
		end else begin
			clock_pin_pullup_en <= clock_pin_pull_ctrl_a & clock_pin_pull_ctrl_b;
			data_pin_pullup_en <= data_pin_pull_ctrl_a & data_pin_pull_ctrl_b;
		end
	end

endmodule // i2c_slave_controller

/* verif/i2c_slave_controller_monitor.sv */
// port-level checker for the serial slave controller
`timescale 1ns/1ps
module i2c_slave_controller_monitor (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic serial_slave_enable,
	input wire logic power_down_req,
	input wire logic prog_debug_mode,
	input wire logic clock_pin_pull_ctrl_a,
	input wire logic clock_pin_pull_ctrl_b,
	input wire logic data_pin_pull_ctrl_a,
	input wire logic data_pin_pull_ctrl_b,
	input wire logic data_read_strobe,
	input wire logic data_write_strobe,
	input wire logic clock_port_pin_oe,
	input wire logic data_port_pin_out,
	input wire logic data_port_pin_oe,
	input wire logic clock_pin_pullup_en,
	input wire logic data_pin_pullup_en,
	input wire logic address_match_flag,
	input wire logic receive_buffer_full_flag,
	input wire logic transmit_buffer_full_flag,
	input wire logic data_overflow_flag,
	input wire logic powered_down
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// pin ownership while the interface is active, and pull-up enables
	scl_left_free_a: assert property ((serial_slave_enable && !powered_down) [*3] |-> !clock_port_pin_oe)
		else $error("slave drives the clock line");
	sda_low_only_a: assert property ((serial_slave_enable && !powered_down) [*3]
		|-> !(data_port_pin_oe && data_port_pin_out)) else $error("data line driven high");
	pull_and_a: assert property ($past(rst_b) |-> clock_pin_pullup_en ==
		$past(clock_pin_pull_ctrl_a && clock_pin_pull_ctrl_b) && data_pin_pullup_en ==
		$past(data_pin_pull_ctrl_a && data_pin_pull_ctrl_b)) else $error("pull-up enable wrong");
	// power-down handling
	pd_refused_a: assert property (prog_debug_mode && !power_down_req && !powered_down
		|=> !powered_down) else $error("power-down taken in debug mode");
	pd_sticky_a: assert property (powered_down |=> powered_down) else $error("power-down lost");
	// buffer flags and address-match acknowledge
	rbf_clear_a: assert property (data_read_strobe |=> !receive_buffer_full_flag)
		else $error("receive full not cleared by read");
	tbf_set_a: assert property (data_write_strobe && !transmit_buffer_full_flag
		|=> transmit_buffer_full_flag) else $error("transmit full not set");
	ovf_write_a: assert property (data_write_strobe && transmit_buffer_full_flag
		|=> data_overflow_flag) else $error("write overflow missed");
	match_ack_a: assert property ($rose(address_match_flag) |-> ##[0:8] data_port_pin_oe)
		else $error("address match without acknowledge");
	cover property ($rose(address_match_flag));
	cover property ($rose(data_overflow_flag));
	cover property ($rose(powered_down));
	cover property ($rose(receive_buffer_full_flag));
endmodule // i2c_slave_controller_monitor
bind i2c_slave_controller i2c_slave_controller_monitor i2c_slave_controller_monitor_i (
	.clk_sys, .rst_b, .serial_slave_enable, .power_down_req, .prog_debug_mode,
	.clock_pin_pull_ctrl_a, .clock_pin_pull_ctrl_b, .data_pin_pull_ctrl_a,
	.data_pin_pull_ctrl_b, .data_read_strobe, .data_write_strobe, .clock_port_pin_oe,
	.data_port_pin_out, .data_port_pin_oe, .clock_pin_pullup_en, .data_pin_pullup_en,
	.address_match_flag, .receive_buffer_full_flag, .transmit_buffer_full_flag,
	.data_overflow_flag, .powered_down
);

/* verif/i2c_master.sv */
// bus master model: makes scl, start and stop, pulls sda low only
`timescale 1ns/1ps
module i2c_master (
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	localparam time HALF = 160; // scl high time; one clk_bit pulse lasts 360 ns
	// clock stands high outside frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic start();
		sda_low = 1'b0;
		#HALF;
		scl = 1'b1;
		#HALF;
		sda_low = 1'b1;
		#HALF;
		scl = 1'b0;
	endtask
	task automatic stop();
		#(HALF/4);
		sda_low = 1'b1;
		#HALF;
		scl = 1'b1;
		#HALF;
		sda_low = 1'b0;
		#HALF;
	endtask
	// one clock pulse; a one is sent by releasing the line
	task automatic clk_bit(input logic b, output logic r);
		#(HALF/4);
		sda_low = !b;
		#HALF;
		scl = 1'b1;
		#HALF;
		r = sda;
		scl = 1'b0;
	endtask
	// eight bits msb first, then the acknowledge pulse
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], q[i]);
		end
		clk_bit(ack_in, ack_out);
	endtask
endmodule // i2c_master

/* verif/tb_i2c_slave_controller.sv */
// self-checking bench for the serial slave controller
`timescale 1ns/1ps
module tb_i2c_slave_controller;
	logic clk_sys = 1'b0, rst_b = 1'b0, serial_slave_enable = 1'b0, general_call_enable = 1'b0;
	logic power_down_req = 1'b0, bus_power_down_cmd = 1'b0, prog_debug_mode = 1'b0;
	logic clock_pin_pull_ctrl_a = 1'b0, clock_pin_pull_ctrl_b = 1'b0;
	logic data_pin_pull_ctrl_a = 1'b0, data_pin_pull_ctrl_b = 1'b0, sw_clock_pin_out = 1'b1;
	logic sw_clock_pin_oe = 1'b0, sw_data_pin_out = 1'b0, sw_data_pin_oe = 1'b0;
	logic data_read_strobe = 1'b0, data_write_strobe = 1'b0, flag_clear_strobe = 1'b0;
	logic [7:0] data_write_value = 8'h00, shared_data_register, q;
	logic clock_port_pin_out, clock_port_pin_oe, data_port_pin_out, data_port_pin_oe, a;
	logic clock_pin_pullup_en, data_pin_pullup_en, address_match_flag, receive_buffer_full_flag;
	logic transmit_buffer_full_flag, read_direction_flag, stop_received_flag, data_overflow_flag;
	logic powered_down, scl_m, sda_low_m;
	int n_fail = 0, comparisons = 0;
	// open-drain lines with pull-ups
	wire clock_port_pin_in = scl_m & ~(clock_port_pin_oe & ~clock_port_pin_out);
	wire data_port_pin_in = ~sda_low_m & ~(data_port_pin_oe & ~data_port_pin_out);
	always #20 clk_sys = ~clk_sys;
	i2c_slave_controller i2c_slave_controller_i (.clk_sys, .rst_b, .serial_slave_enable,
		.general_call_enable, .power_down_req, .bus_power_down_cmd, .prog_debug_mode,
		.clock_pin_pull_ctrl_a, .clock_pin_pull_ctrl_b, .data_pin_pull_ctrl_a,
		.data_pin_pull_ctrl_b, .sw_clock_pin_out, .sw_clock_pin_oe, .sw_data_pin_out,
		.sw_data_pin_oe, .clock_port_pin_in, .data_port_pin_in, .data_read_strobe,
		.data_write_strobe, .data_write_value, .flag_clear_strobe, .clock_port_pin_out,
		.clock_port_pin_oe, .data_port_pin_out, .data_port_pin_oe, .clock_pin_pullup_en,
		.data_pin_pullup_en, .shared_data_register, .address_match_flag,
		.receive_buffer_full_flag, .transmit_buffer_full_flag, .read_direction_flag,
		.stop_received_flag, .data_overflow_flag, .powered_down);
	i2c_master i2c_master_i (.sda(data_port_pin_in), .scl(scl_m), .sda_low(sda_low_m));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask
	// pin sync plus flag update latency
	task automatic settle();
		repeat (8) @(negedge clk_sys);
	endtask
	// one-cycle software strobe: 8 read, 4 write, 2 flag clear, 1 bus power-down
	task automatic strobe(input logic [3:0] sel);
		@(negedge clk_sys);
		{data_read_strobe, data_write_strobe, flag_clear_strobe, bus_power_down_cmd} = sel;
		@(negedge clk_sys);
		{data_read_strobe, data_write_strobe, flag_clear_strobe, bus_power_down_cmd} = 4'h0;
	endtask
	task automatic sw_write(input logic [7:0] v);
		data_write_value = v;
		strobe(4'h4);
		settle();
	endtask
	task automatic t_rx();
		i2c_master_i.start();
		i2c_master_i.xfer(8'h6c, 1'b1, q, a);
		settle();
		chk_bit(a, 1'b0);
		chk_bit(address_match_flag, 1'b1);
		chk_bit(read_direction_flag, 1'b0);
		i2c_master_i.xfer(8'ha5, 1'b1, q, a);
		settle();
		chk_bit(a, 1'b0);
		chk_bit(receive_buffer_full_flag, 1'b1);
		chk(shared_data_register, 8'ha5);
		chk_bit(data_overflow_flag, 1'b0);
		i2c_master_i.xfer(8'h5a, 1'b1, q, a);
		settle();
		chk_bit(data_overflow_flag, 1'b1);
		strobe(4'h8);
		settle();
		chk_bit(receive_buffer_full_flag, 1'b0);
		chk_bit(stop_received_flag, 1'b0);
		i2c_master_i.stop();
		settle();
		chk_bit(stop_received_flag, 1'b1);
		$display("test rx done");
	endtask
	task automatic t_miss();
		strobe(4'h2);
		i2c_master_i.start();
		i2c_master_i.xfer(8'h6e, 1'b1, q, a);
		settle();
		chk_bit(a, 1'b1);
		chk_bit(address_match_flag, 1'b0);
		i2c_master_i.xfer(8'h6c, 1'b1, q, a);
		chk_bit(a, 1'b1);
		i2c_master_i.stop();
		$display("test address miss done");
	endtask
	task automatic t_tx();
		strobe(4'h2);
		sw_write(8'h3c);
		chk_bit(transmit_buffer_full_flag, 1'b1);
		i2c_master_i.start();
		i2c_master_i.xfer(8'h6d, 1'b1, q, a);
		settle();
		chk_bit(a, 1'b0);
		chk_bit(read_direction_flag, 1'b1);
		chk_bit(transmit_buffer_full_flag, 1'b0);
		sw_write(8'h81);
		chk_bit(data_overflow_flag, 1'b0);
		sw_write(8'h82);
		chk_bit(data_overflow_flag, 1'b1);
		i2c_master_i.xfer(8'hff, 1'b0, q, a);
		chk(q, 8'h3c);
		i2c_master_i.xfer(8'hff, 1'b1, q, a);
		chk(q, 8'h82);
		i2c_master_i.stop();
		$display("test tx done");
	endtask
	task automatic t_pins();
		{serial_slave_enable, sw_data_pin_out, sw_data_pin_oe, sw_clock_pin_oe} = 4'h7;
		settle();
		chk_bit(data_port_pin_out, 1'b1);
		chk_bit(clock_port_pin_oe, 1'b1);
		chk_bit(clock_port_pin_out, 1'b1);
		serial_slave_enable = 1'b1;
		settle();
		chk_bit(clock_port_pin_oe, 1'b0);
		chk_bit(data_port_pin_oe, 1'b0);
		for (int i = 0; i < 16; i++) begin
			{clock_pin_pull_ctrl_a, clock_pin_pull_ctrl_b, data_pin_pull_ctrl_a,
				data_pin_pull_ctrl_b} = i[3:0];
			settle();
			chk_bit(clock_pin_pullup_en, i[3] & i[2]);
			chk_bit(data_pin_pullup_en, i[1] & i[0]);
		end
		prog_debug_mode = 1'b1;
		strobe(4'h1);
		settle();
		chk_bit(powered_down, 1'b0);
		prog_debug_mode = 1'b0;
		strobe(4'h1);
		settle();
		chk_bit(powered_down, 1'b1);
		chk_bit(data_port_pin_out, 1'b1);
		chk_bit(clock_port_pin_oe, 1'b1);
		$display("test pins done");
	endtask
	// mid-run reset wakes the block, then a system power-down request
	task automatic t_reset();
		@(negedge clk_sys);
		rst_b = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk_bit(powered_down, 1'b0);
		rst_b = 1'b1;
		settle();
		chk_bit(powered_down, 1'b0);
		chk_bit(clock_port_pin_oe, 1'b0);
		chk_bit(data_port_pin_oe, 1'b0);
		power_down_req = 1'b1;
		settle();
		power_down_req = 1'b0;
		settle();
		chk_bit(powered_down, 1'b1);
		chk_bit(clock_port_pin_oe, 1'b1);
		chk_bit(clock_port_pin_out, 1'b1);
		$display("test reset done");
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		#1ms;
		n_fail++;
		end_sim();
	end
	// reset, then the scenarios
	initial begin
		repeat (3) @(negedge clk_sys);
		rst_b = 1'b1;
		serial_slave_enable = 1'b1;
		settle();
		t_rx();
		t_miss();
		t_tx();
		t_pins();
		t_reset();
		end_sim();
	end
endmodule // tb_i2c_slave_controller
